/* File: hw/posfu_pkg.sv */
// shared constants, types and helpers of the one-step transmit field updater
`default_nettype none
package posfu_pkg;
	// transmit flag and per-frame update control layout
	localparam int FLAG_W     = 18;
	localparam int CTL_W      = 17;
	localparam int FRAME_BIT  = 17;
	localparam int TAG_LSB    = 0;
	localparam int TAG_W      = 4;
	localparam int REQ_BIT    = 4;
	localparam int PEER_BIT   = 5;
	localparam int UDP_BIT    = 6;
	localparam int OFF_LSB    = 7;
	localparam int OFF_W      = 8;
	localparam int WIDE_BIT   = 15;
	localparam int STAMP_W    = 30;
	localparam int FIELD_BYTES = 8;
	localparam int IDX_W      = 9;
	localparam logic [IDX_W-1:0] FIELD_LAST = 9'h007;
	localparam logic [IDX_W-1:0] IDX_MAX    = 9'h1FF;
	// nanosecond wrap of the timestamp low word
	localparam logic [31:0] NS_PER_SEC = 32'h3B9A_CA00;
	// register map, byte addresses
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_STAMP  = 4'h8;
	localparam int CTRL_EN_BIT  = 0;
	localparam int CTRL_SRC_BIT = 1;
	localparam int STAT_BUSY_BIT = 8;
	localparam logic CTRL_EN_RST  = 1'h0;
	localparam logic CTRL_SRC_RST = 1'h0;

	typedef struct packed {
		logic       vld;
		logic       sop;
		logic       eop;
		logic [7:0] data;
	} posfu_beat_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_BODY  = 2'h1,
		ST_DRAIN = 2'h3
	} posfu_state_t;

	// ones-complement 16-bit add with end-around carry
	function automatic logic [15:0] posfu_oc_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'h0, a} + {1'h0, b};
		posfu_oc_add = s[15:0] + {15'h0000, s[16]};
	endfunction
endpackage
`default_nettype wire

/* File: hw/posfu_if.sv */
// interfaces between the updater core, its register slave and its field arithmetic
`timescale 1ns/1ps
`default_nettype none
interface posfu_cfg_if;
	logic        one_step_feature_enable;
	logic        wide_overwrite_source_select;
	logic [3:0]  last_tag;
	logic        busy;
	logic [31:0] last_stamp;
	modport regs (output one_step_feature_enable, output wide_overwrite_source_select,
		input last_tag, input busy, input last_stamp);
	modport core (input one_step_feature_enable, input wide_overwrite_source_select,
		output last_tag, output busy, output last_stamp);
endinterface

interface posfu_calc_if;
	logic [63:0] old_field;
	logic [63:0] new_field;
	logic [63:0] cnt;
	logic [29:0] stamp;
	logic [29:0] peer;
	logic        wide;
	logic        peer_add;
	logic        src_sel;
	logic [15:0] cs_delta;
	modport calc (input old_field, input cnt, input stamp, input peer, input wide,
		input peer_add, input src_sel, output new_field, output cs_delta);
	modport core (output old_field, output cnt, output stamp, output peer, output wide,
		output peer_add, output src_sel, input new_field, input cs_delta);
endinterface
`default_nettype wire

/* File: hw/posfu_field_calc.sv */
// new field value and checksum compensation for one updated 64-bit field
`timescale 1ns/1ps
`default_nettype none
module posfu_field_calc (
	posfu_calc_if.calc c // field operands and results
);
	import posfu_pkg::*;

	logic [31:0] stamp32;
	logic [31:0] transient;
	logic [31:0] total;
	logic [15:0] acc;

	always_comb begin
		stamp32 = {2'h0, c.stamp};
		// nanosecond counter may wrap between the two stamps
		if (c.cnt[31:0] < stamp32) begin
			transient = c.cnt[31:0] + (NS_PER_SEC - stamp32);
		end else begin
			transient = c.cnt[31:0] - stamp32;
		end
		total = transient + (c.peer_add ? {2'h0, c.peer} : 32'h0000_0000);
		if (c.wide) begin
			// plain overwrite, no arithmetic
			c.new_field = c.src_sel ? c.cnt : {2'h0, c.stamp, c.cnt[31:0]};
		end else begin
			// field holds nanoseconds scaled by 2^16
			c.new_field = c.old_field + {16'h0000, total, 16'h0000};
		end
		acc = 16'h0000;
		for (int i = 0; i < 4; i++) begin
			acc = posfu_oc_add(acc, c.old_field[16*i +: 16]);
			acc = posfu_oc_add(acc, ~c.new_field[16*i +: 16]);
		end
		c.cs_delta = acc;
	end
endmodule
`default_nettype wire

/* File: hw/posfu_wb_regs.sv */
// classic wishbone register slave of the updater
`timescale 1ns/1ps
`default_nettype none
module posfu_wb_regs (
	input  wire logic        core_clk, // clock
	input  wire logic        nrst,     // synchronous reset, active low
	input  wire logic        wb_cyc_i, // bus cycle
	input  wire logic        wb_stb_i, // strobe
	input  wire logic        wb_we_i,  // write enable
	input  wire logic [3:0]  wb_adr_i, // byte address
	input  wire logic [3:0]  wb_sel_i, // byte lanes
	input  wire logic [31:0] wb_dat_i, // write data
	output logic      [31:0] wb_dat_o, // read data
	output logic             wb_ack_o, // acknowledge
	posfu_cfg_if.regs        cfg       // core side
);
	import posfu_pkg::*;

	logic req;

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wb_ack_o <= 1'h0;
		end else begin
			wb_ack_o <= req;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cfg.one_step_feature_enable      <= CTRL_EN_RST;
			cfg.wide_overwrite_source_select <= CTRL_SRC_RST;
		end else if (req && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
			cfg.one_step_feature_enable      <= wb_dat_i[CTRL_EN_BIT];
			cfg.wide_overwrite_source_select <= wb_dat_i[CTRL_SRC_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req && !wb_we_i) begin
			case (wb_adr_i)
				REG_CTRL: begin
					wb_dat_o <= {30'h0000_0000, cfg.wide_overwrite_source_select,
						cfg.one_step_feature_enable};
				end
				REG_STATUS: begin
					wb_dat_o <= {23'h00_0000, cfg.busy, 4'h0, cfg.last_tag};
				end
				REG_STAMP: begin
					wb_dat_o <= cfg.last_stamp;
				end
				default: begin
					wb_dat_o <= 32'h0000_0000;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: hw/posfu_top.sv */
// one-step transmit field updater: correction update or 64-bit overwrite in flight
// Functional notes
// - correction-field update only when control bit 15 is zero
// - with the feature enable clear, control bits 15..4 are ignored; the bits 3..0 tag is still returned
// - control vector counts only when transmit flag bit 17 is set
// - bits 3..0 are an opaque tag returned after the frame is sent
// - bit 4 requests an update; when clear, higher bits are ignored
// - bit 5 adds the peer delay besides the transient time
// - bit 6 fixes the last two payload bytes to keep the UDP checksum
// - bits 14..7 give byte offset to the field's most significant byte
// - bit 15 set overwrites eight bytes MSB first, bits 5 and 6 zero
// - overwrite value is flag stamp with counter low, or full counter
// - message type is not inspected; sender asks only for event messages
// - multi-byte fields are network order, first byte most significant
// - transient time is counter at transmission minus flag stamp
// - sent stamp valid pulses for exactly one cycle
`timescale 1ns/1ps
`default_nettype none
module posfu_top #(
	parameter int DEPTH = posfu_pkg::FIELD_BYTES // byte delay line length
) (
	input  wire logic                         core_clk,             // clock, 10 MHz
	input  wire logic                         nrst,                 // synchronous reset, active low
	input  wire logic                         wb_cyc_i,             // wishbone cycle
	input  wire logic                         wb_stb_i,             // wishbone strobe
	input  wire logic                         wb_we_i,              // wishbone write
	input  wire logic [3:0]                   wb_adr_i,             // wishbone byte address
	input  wire logic [3:0]                   wb_sel_i,             // wishbone byte lanes
	input  wire logic [31:0]                  wb_dat_i,             // wishbone write data
	output logic      [31:0]                  wb_dat_o,             // wishbone read data
	output logic                              wb_ack_o,             // wishbone acknowledge
	input  wire logic                         in_valid,             // frame byte valid
	output logic                              in_ready,             // frame byte accepted
	input  wire logic [7:0]                   in_data,              // frame byte
	input  wire logic                         in_sop,               // first byte of frame
	input  wire logic                         in_eop,               // last byte before crc
	input  wire logic [posfu_pkg::FLAG_W-1:0] tx_flags,             // transmit flags, held at sop
	input  wire logic [posfu_pkg::STAMP_W-1:0] tx_stamp,            // flag timestamp, held at sop
	input  wire logic [63:0]                  free_running_counter, // time counter
	input  wire logic [29:0]                  peer_delay,           // ingress link delay
	input  wire logic                         peer_delay_val,       // peer delay valid
	output logic                              out_valid,            // output byte valid
	output logic      [7:0]                   out_data,             // output byte
	output logic                              out_sop,              // output first byte
	output logic                              out_eop,              // output last byte
	output logic                              sent_stamp_valid,     // frame sent pulse
	output logic      [63:0]                  sent_stamp_value,     // counter when frame left
	output logic      [3:0]                   sent_frame_tag_out    // returned frame tag
);
	import posfu_pkg::*;

	generate
		if (DEPTH < FIELD_BYTES) begin : g_depth_check
			$error("delay line shorter than the updated field");
		end
	endgenerate

	posfu_cfg_if  cfg ();
	posfu_calc_if calc ();

	posfu_beat_t               line [DEPTH];
	posfu_beat_t               base_line [DEPTH];
	posfu_beat_t               next_line [DEPTH];
	posfu_state_t              state;
	posfu_state_t              next_state;
	logic                      fr_flag;
	logic [CTL_W-1:0]          fr_ctl;
	logic [STAMP_W-1:0]        fr_stamp;
	logic [IDX_W-1:0]          idx;
	logic [IDX_W-1:0]          cur_idx;
	logic [IDX_W-1:0]          field_end;
	logic [29:0]               peer_q;
	logic [15:0]               cs_adj;
	logic                      cs_pend;
	logic [63:0]               old_field;
	logic                      accept;
	logic                      advance;
	logic                      act;
	logic                      wide;
	logic                      udp_act;
	logic                      field_hit;
	logic                      fix_hit;
	logic                      tail_in_sop;
	logic                      tail_in_eop;

	posfu_field_calc u_calc (
		.c (calc)
	);

	posfu_wb_regs u_regs (
		.core_clk (core_clk),
		.nrst     (nrst),
		.wb_cyc_i (wb_cyc_i),
		.wb_stb_i (wb_stb_i),
		.wb_we_i  (wb_we_i),
		.wb_adr_i (wb_adr_i),
		.wb_sel_i (wb_sel_i),
		.wb_dat_i (wb_dat_i),
		.wb_dat_o (wb_dat_o),
		.wb_ack_o (wb_ack_o),
		.cfg      (cfg)
	);

	assign accept  = in_valid && in_ready;
	// a frame whose last byte is inside keeps moving with no input
	assign advance = accept || (state == ST_DRAIN);
	assign cur_idx = in_sop ? '0 : idx;
	assign field_end = {1'h0, fr_ctl[OFF_LSB +: OFF_W]} + FIELD_LAST;

	// frame type is never looked at, only the control bits
	assign act     = fr_flag && cfg.one_step_feature_enable && fr_ctl[REQ_BIT];
	assign wide    = fr_ctl[WIDE_BIT];
	assign udp_act = act && !wide && fr_ctl[UDP_BIT];
	assign field_hit = accept && !in_sop && act && cur_idx == field_end;
	assign fix_hit   = accept && in_eop && udp_act && cs_pend;

	assign tail_in_sop = advance && line[DEPTH-2].vld && line[DEPTH-2].sop;
	assign tail_in_eop = advance && line[DEPTH-2].vld && line[DEPTH-2].eop;

	assign calc.old_field = old_field;
	assign calc.cnt       = free_running_counter;
	assign calc.stamp     = fr_stamp;
	assign calc.peer      = peer_q;
	assign calc.wide      = wide;
	assign calc.peer_add  = !wide && fr_ctl[PEER_BIT];
	assign calc.src_sel   = cfg.wide_overwrite_source_select;

	assign out_valid = line[DEPTH-1].vld;
	assign out_data  = line[DEPTH-1].data;
	assign out_sop   = line[DEPTH-1].sop;
	assign out_eop   = line[DEPTH-1].eop;

	assign cfg.last_tag   = sent_frame_tag_out;
	assign cfg.busy       = state != ST_IDLE;
	assign cfg.last_stamp = sent_stamp_value[31:0];

	// shifted line before any field rewrite
	always_comb begin
		base_line[0].vld  = accept;
		base_line[0].sop  = accept && in_sop;
		base_line[0].eop  = accept && in_eop;
		base_line[0].data = in_data;
		for (int i = 1; i < DEPTH; i++) begin
			base_line[i] = line[i-1];
		end
	end

	// newest byte is least significant: first byte sent is the MSB
	always_comb begin
		old_field = '0;
		for (int j = 0; j < FIELD_BYTES; j++) begin
			old_field[8*j +: 8] = base_line[j].data;
		end
	end

	always_comb begin
		logic [15:0] last_word;
		last_word = {base_line[1].data, base_line[0].data};
		for (int i = 0; i < DEPTH; i++) begin
			next_line[i] = base_line[i];
		end
		if (field_hit) begin
			for (int j = 0; j < FIELD_BYTES; j++) begin
				next_line[j].data = calc.new_field[8*j +: 8];
			end
		end else if (fix_hit) begin
			last_word = posfu_oc_add(last_word, cs_adj);
			next_line[1].data = last_word[15:8];
			next_line[0].data = last_word[7:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			for (int i = 0; i < DEPTH; i++) begin
				line[i] <= '0;
			end
		end else if (advance) begin
			for (int i = 0; i < DEPTH; i++) begin
				line[i] <= next_line[i];
			end
		end else begin
			// a presented byte is shown once only
			line[DEPTH-1].vld <= 1'h0;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (accept && in_sop) begin
					next_state = in_eop ? ST_DRAIN : ST_BODY;
				end
			end
			ST_BODY: begin
				if (accept && in_eop) begin
					next_state = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				if (tail_in_eop) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state    <= ST_IDLE;
			in_ready <= 1'h0;
		end else begin
			state    <= next_state;
			in_ready <= next_state != ST_DRAIN;
		end
	end

	// per-frame control, taken with the first byte
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			fr_flag  <= 1'h0;
			fr_ctl   <= '0;
			fr_stamp <= '0;
		end else if (accept && in_sop) begin
			fr_flag  <= tx_flags[FRAME_BIT];
			fr_ctl   <= tx_flags[CTL_W-1:0];
			fr_stamp <= tx_stamp;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			idx <= '0;
		end else if (accept) begin
			if (in_sop) begin
				idx <= {{(IDX_W-1){1'h0}}, 1'h1};
			end else if (idx != IDX_MAX) begin
				idx <= idx + {{(IDX_W-1){1'h0}}, 1'h1};
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			peer_q <= '0;
		end else if (peer_delay_val) begin
			peer_q <= peer_delay;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cs_adj  <= 16'h0000;
			cs_pend <= 1'h0;
		end else if (accept && in_sop) begin
			cs_pend <= 1'h0;
		end else if (field_hit && udp_act) begin
			cs_adj  <= calc.cs_delta;
			cs_pend <= 1'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			sent_stamp_value <= 64'h0000_0000_0000_0000;
		end else if (tail_in_sop) begin
			sent_stamp_value <= free_running_counter;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			sent_stamp_valid   <= 1'h0;
			sent_frame_tag_out <= 4'h0;
		end else begin
			sent_stamp_valid <= tail_in_eop && fr_flag;
			if (tail_in_eop && fr_flag) begin
				sent_frame_tag_out <= fr_ctl[TAG_LSB +: TAG_W];
			end
		end
	end

	// checking helpers
	logic [63:0] field_now;
	logic [31:0] exp_tr;
	logic [31:0] cnt_lo;
	logic [31:0] st32;

	assign cnt_lo = free_running_counter[31:0];
	assign st32   = {2'h0, fr_stamp};

	always_comb begin
		field_now = '0;
		for (int j = 0; j < FIELD_BYTES; j++) begin
			field_now[8*j +: 8] = line[j].data;
		end
		if (cnt_lo >= st32) begin
			exp_tr = cnt_lo - st32;
		end else begin
			exp_tr = NS_PER_SEC - st32 + cnt_lo;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	sequence s_corr_hit;
		field_hit && !wide && !fr_ctl[PEER_BIT];
	endsequence

	sequence s_peer_hit;
		field_hit && !wide && fr_ctl[PEER_BIT];
	endsequence

	sequence s_last_in;
		accept && in_eop;
	endsequence

	stamp_pulse_a: assert property (sent_stamp_valid |=> !sent_stamp_valid)
		else $error("sent stamp valid longer than one cycle");

	tag_return_a: assert property (sent_stamp_valid |-> out_eop && out_valid &&
		sent_frame_tag_out == fr_ctl[TAG_LSB +: TAG_W])
		else $error("frame tag not returned with last byte");

	off_pass_a: assert property (!cfg.one_step_feature_enable && accept |=>
		line[0].data == $past(in_data))
		else $error("byte changed with feature disabled");

	flag_gate_a: assert property ((!fr_flag || !fr_ctl[REQ_BIT]) && accept && !in_sop |=>
		line[0].data == $past(in_data))
		else $error("byte changed without frame flag or request");

	corr_add_a: assert property (s_corr_hit |=>
		field_now - $past(old_field) == {16'h0000, $past(exp_tr), 16'h0000})
		else $error("correction field not advanced by transient time");

	peer_add_a: assert property (s_peer_hit |=>
		field_now - $past(old_field) == {16'h0000, $past(exp_tr) + {2'h0, $past(peer_q)}, 16'h0000})
		else $error("peer delay not added to correction");

	wide_src_a: assert property (field_hit && wide |=> field_now == ($past(cfg.wide_overwrite_source_select)
		? $past(free_running_counter) : {2'h0, $past(fr_stamp), $past(cnt_lo)}))
		else $error("overwrite value wrong");

	udp_fix_a: assert property (fix_hit && !field_hit |=> {line[1].data, line[0].data} ==
		posfu_oc_add({$past(line[0].data), $past(in_data)}, $past(cs_adj)))
		else $error("checksum bytes not compensated");

	drain_stop_a: assert property (s_last_in ##1 1'h1 |-> !in_ready)
		else $error("input taken while frame drains");

	wrap_mod_a: assert property (s_corr_hit |=> $past(cnt_lo >= st32) || field_now - $past(old_field) ==
		{16'h0000, $past(cnt_lo) + NS_PER_SEC - $past(st32), 16'h0000}) else $error("transient wrap wrong");
endmodule
`default_nettype wire

/* File: testbench/posfu_src_model.sv */
// frame source standing in for the user fabric transmit logic
`timescale 1ns/1ps
`default_nettype none
module posfu_src_model (
	input  wire logic        core_clk, // clock
	input  wire logic        in_ready, // byte taken
	input  wire logic [63:0] cnt,      // time counter
	output logic             in_valid, // byte valid
	output logic       [7:0] in_data,  // frame byte
	output logic             in_sop,   // first byte
	output logic             in_eop,   // last byte
	output logic      [17:0] flags,    // transmit flags
	output logic      [29:0] stamp     // flag timestamp
);
	logic [7:0]  fbuf [0:255];
	logic [63:0] acnt [0:255];
	initial begin
		{in_valid, in_sop, in_eop, in_data, flags, stamp} = '0;
	end
	// flags count only at sop, so they are scrambled once it is taken
	task automatic send(input int len, input logic [17:0] fl, input logic [29:0] st);
		int i;
		i = 0;
		flags <= fl;
		stamp <= st;
		while (i < len) begin
			in_valid <= 1'b1;
			in_data  <= fbuf[i];
			in_sop   <= i == 0;
			in_eop   <= i == len - 1;
			@(posedge core_clk);
			if (in_ready === 1'b1) begin
				acnt[i] = cnt;
				i++;
				flags <= ~fl;
				stamp <= ~st;
				if (i % 5 == 3) begin
					in_valid <= 1'b0;
					in_data  <= ~fbuf[i - 1];
					@(posedge core_clk);
				end
			end
		end
		in_valid <= 1'b0;
		in_data  <= ~fbuf[len - 1];
		in_sop   <= 1'b0;
		in_eop   <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: testbench/posfu_top_tb.sv */
// self-checking bench of the one-step transmit field updater
`timescale 1ns/1ps
`default_nettype none
module posfu_top_tb;
	import posfu_pkg::*;
	logic        core_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, prev_v;
	logic [3:0]  wb_adr_i, wb_sel_i, sent_frame_tag_out, ptag, etag;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic        in_valid, in_ready, in_sop, in_eop, out_valid, out_sop, out_eop;
	logic        sent_stamp_valid, peer_delay_val;
	logic [7:0]  in_data, out_data;
	logic [17:0] tx_flags;
	logic [29:0] tx_stamp, peer_delay;
	logic [63:0] free_running_counter, sent_stamp_value, last_cnt, sop_cnt;
	logic [7:0]  oq [$];
	logic [7:0]  ex [0:255];
	int          error_cnt, total_checks, pulses, cyc, seed;

	posfu_top #(.DEPTH(8)) dut_u (.core_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .in_valid, .in_ready, .in_data, .in_sop, .in_eop,
		.tx_flags, .tx_stamp, .free_running_counter, .peer_delay, .peer_delay_val, .out_valid,
		.out_data, .out_sop, .out_eop, .sent_stamp_valid, .sent_stamp_value, .sent_frame_tag_out);
	posfu_src_model src_u (.core_clk, .in_ready, .cnt(free_running_counter), .in_valid, .in_data,
		.in_sop, .in_eop, .flags(tx_flags), .stamp(tx_stamp));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// counter steps in true nanoseconds and wraps its low word
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (free_running_counter[31:0] >= NS_PER_SEC - 32'h0000_0064)
			free_running_counter <= {free_running_counter[63:32] + 32'h0000_0001,
				free_running_counter[31:0] + 32'h0000_0064 - NS_PER_SEC};
		else
			free_running_counter[31:0] <= free_running_counter[31:0] + 32'h0000_0064;
		if (out_valid === 1'b1) begin
			if (out_sop === 1'b1)
				oq.delete();
			oq.push_back(out_data);
		end
		// counter seen at the edge that moved the first byte into the output stage
		if (out_valid === 1'b1 && out_sop === 1'b1) begin
			sop_cnt = last_cnt;
			chk("sent stamp", last_cnt, sent_stamp_value);
		end
		last_cnt <= free_running_counter;
		if (sent_stamp_valid === 1'b1) begin
			pulses++;
			ptag = sent_frame_tag_out;
		end
		if (sent_stamp_valid === 1'b1 && prev_v === 1'b1)
			chk("pulse width", 0, 1);
		prev_v <= sent_stamp_valid;
		if (cyc == 30000) begin
			error_cnt++;
			results();
		end
	end

	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
		@(posedge core_clk);
		// wb_ack_o ends this wait; without an ack the bench timeout ends it
		while (wb_ack_o !== 1'b1)
			@(posedge core_clk);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge core_clk);
	endtask

	function automatic logic [16:0] mk(input logic w, input logic [7:0] off, input logic u,
		input logic p, input logic r, input logic [3:0] tag);
		return {1'b0, w, off, u, p, r, tag};
	endfunction

	function automatic logic [63:0] fnew(input logic [63:0] o, input logic [16:0] c, input logic s,
		input logic [29:0] st, input logic [63:0] k, input logic [29:0] pd);
		logic [63:0] t;
		if (c[WIDE_BIT])
			return s ? k : {2'b00, st, k[31:0]};
		t = (64'(k[31:0]) + 64'(NS_PER_SEC) - 64'(st)) % 64'(NS_PER_SEC);
		if (c[PEER_BIT])
			t = t + 64'(pd);
		return o + (t << 16);
	endfunction

	function automatic int osum(input logic [63:0] f, input logic [15:0] l);
		return (int'(f[63:48]) + int'(f[47:32]) + int'(f[31:16]) + int'(f[15:0]) + int'(l)) % 65535;
	endfunction

	task automatic run(input logic fr, input logic en, input logic s, input logic [16:0] c, input int len);
		logic [63:0] of, nf;
		logic [29:0] st;
		logic        upd;
		int          o, p0;
		o = int'(c[14:7]);
		p0 = pulses;
		st = 30'($unsigned($random(seed)) % NS_PER_SEC);
		wb(1'b1, REG_CTRL, {30'h0000_0000, s, en});
		peer_delay <= 30'($random(seed));
		peer_delay_val <= 1'b1;
		for (int i = 0; i < len; i++)
			src_u.fbuf[i] = 8'($random(seed));
		@(posedge core_clk);
		peer_delay_val <= 1'b0;
		src_u.send(len, {fr, c}, st);
		while (!(out_valid === 1'b1 && out_eop === 1'b1))
			@(posedge core_clk);
		@(posedge core_clk);
		for (int i = 0; i < len; i++)
			ex[i] = src_u.fbuf[i];
		for (int i = 0; i < 8; i++)
			of = {of[55:0], ex[o + i]};
		upd = fr && en && c[REQ_BIT];
		nf = upd ? fnew(of, c, s, st, src_u.acnt[o + 7], peer_delay) : of;
		for (int i = 0; i < 8; i++)
			ex[o + i] = nf[63 - 8 * i -: 8];
		chk("length", len, oq.size());
		for (int i = 0; i < len - 2; i++)
			chk("byte", ex[i], oq[i]);
		if (upd && c[UDP_BIT] && !c[WIDE_BIT])
			chk("checksum", osum(of, {ex[len - 2], ex[len - 1]}), osum(nf, {oq[len - 2], oq[len - 1]}));
		else
			chk("tail", {ex[len - 2], ex[len - 1]}, {oq[len - 2], oq[len - 1]});
		chk("pulses", 64'(p0 + fr), 64'(pulses));
		if (fr)
			chk("tag", c[3:0], ptag);
		etag = fr ? c[3:0] : etag;
		wb(1'b0, REG_STATUS, 32'h0000_0000);
		chk("status", {60'h0, etag}, rd);
		wb(1'b0, REG_STAMP, 32'h0000_0000);
		chk("stamp reg", {32'h0000_0000, sop_cnt[31:0]}, rd);
		$display("frame test done, control %h", c);
	endtask

	initial begin
		logic       w;
		logic [7:0] off;
		seed = 19;
		{nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, peer_delay, peer_delay_val} = '0;
		wb_sel_i = 4'hF;
		free_running_counter = {32'h0000_0005, NS_PER_SEC - 32'h0000_4E20};
		{cyc, prev_v, pulses, error_cnt, total_checks} = '0;
		etag = 4'h0;
		repeat (8) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		wb(1'b0, REG_CTRL, 32'h0000_0000);
		chk("ctrl reset", 0, rd);
		wb(1'b0, 4'hC, 32'h0000_0000);
		chk("unmapped read", 0, rd);
		run(1'b0, 1'b1, 1'b0, mk(0, 8'h16, 0, 0, 1, 4'h3), 64);
		run(1'b1, 1'b0, 1'b0, mk(0, 8'h16, 0, 0, 1, 4'h5), 64);
		run(1'b1, 1'b1, 1'b0, mk(0, 8'h16, 1, 1, 0, 4'h6), 64);
		run(1'b1, 1'b1, 1'b0, mk(0, 8'h16, 0, 0, 1, 4'h7), 64);
		run(1'b1, 1'b1, 1'b0, mk(0, 8'h32, 0, 1, 1, 4'h8), 64);
		run(1'b1, 1'b1, 1'b0, mk(0, 8'h32, 1, 0, 1, 4'h9), 64);
		run(1'b1, 1'b1, 1'b0, mk(1, 8'h10, 0, 0, 1, 4'hA), 64);
		run(1'b1, 1'b1, 1'b1, mk(1, 8'h46, 0, 0, 1, 4'hF), 80);
		for (int k = 0; k < 12; k++) begin
			w = 1'($random(seed));
			off = 8'h10 + 8'(2 * ($unsigned($random(seed)) % 24));
			run(1'b1, 1'b1, 1'($random(seed)), mk(w, off, !w && 1'($random(seed)), !w && 1'($random(seed)),
				1'b1, 4'($random(seed))), int'(off) + 12 + 2 * ($unsigned($random(seed)) % 8));
		end
		results();
	end
endmodule
`default_nettype wire
